// [design/uatx_top.sv]
// Serial transmitter and receiver with a one-byte transmit buffer.
// Assumes APB registers, synchronous RXD input and a single clock.
`timescale 1ns/1ns
module uatx_top
	import uatx_pkg::*;
#(
	parameter int DIV_W = 16 // Width of the baud divider
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RXD,
	output logic             TXD,
	output logic             IRQ
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]       ctrl_q;          // Control register
	logic [DIV_W-1:0] baud_q;          // Bit period in clocks, minus one
	logic [7:0]       txbuf_q;         // Transmit buffer
	logic             txfull_q;        // Buffer holds a byte
	logic [7:0]       txsh_q;          // Transmit shift register
	uatx_tx_e         txst_q;          // Transmit state
	logic [DIV_W-1:0] txcnt_q;         // Transmit bit timer
	logic [2:0]       txbit_q;         // Transmit bit index
	logic             txstop2_q;       // Second stop bit pending
	logic [7:0]       rxbuf_q;         // Receive buffer
	logic             rxfull_q;        // Unread byte present
	logic [7:0]       rxsh_q;          // Receive shift register
	uatx_rx_e         rxst_q;          // Receive state
	logic [DIV_W-1:0] rxcnt_q;         // Receive bit timer
	logic [2:0]       rxbit_q;         // Receive bit index
	uatx_err_s        err_q;           // Reception error status
	logic [2:0]       irqst_q;         // Sticky interrupt status
	logic [2:0]       irqmask_q;       // Interrupt enables
	logic             acc, wr, rd;     // APB access strobes
	logic             tx_done, rx_done, rx_err; // One-cycle events
	logic             tx_tick, rx_tick; // Bit timer expiry
	logic             tx_load;         // Shifter takes buffer
	logic [31:0]      rdata_d;         // Read mux

	// Decode one address against an offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign acc     = PSEL & PENABLE;
	assign wr      = acc & PWRITE;
	// Read side effects fall on the edge that latches PRDATA, so an event
	// landing between setup and access is never cleared unreported
	assign rd      = PSEL & ~PENABLE & ~PWRITE;
	assign tx_tick = (txcnt_q == '0);
	assign rx_tick = (rxcnt_q == '0);
	assign tx_load = (txst_q == TX_IDLE) & txfull_q & ctrl_q[CTL_TXEN_BIT];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Configuration registers
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl_q    <= CTRL_RST;
			baud_q    <= BAUD_RST[DIV_W-1:0];
			irqmask_q <= '0;
		end else if (wr) begin
			if (hit(PADDR, OFF_CTRL))    ctrl_q    <= PWDATA[7:0];
			if (hit(PADDR, OFF_BAUD))    baud_q    <= PWDATA[DIV_W-1:0];
			if (hit(PADDR, OFF_IRQMASK)) irqmask_q <= PWDATA[2:0];
		end
	end

	// Read data mux; unmapped reads return zero
	always_comb begin
		rdata_d = '0;
		if (hit(PADDR, OFF_CTRL))    rdata_d[7:0] = ctrl_q;
		if (hit(PADDR, OFF_BAUD))    rdata_d[DIV_W-1:0] = baud_q;
		if (hit(PADDR, OFF_RXDATA))  rdata_d[7:0] = rxbuf_q;
		if (hit(PADDR, OFF_TXSTAT)) begin
			rdata_d[TXS_FULL_BIT]  = txfull_q;
			// Busy covers the load cycle too, so full never shows with an idle shifter while the transmitter is enabled
			rdata_d[TXS_SHIFT_BIT] = (txst_q != TX_IDLE) | tx_load;
		end
		if (hit(PADDR, OFF_ERRSTAT)) rdata_d[1:0] = err_q;
		if (hit(PADDR, OFF_IRQSTAT)) rdata_d[2:0] = irqst_q;
		if (hit(PADDR, OFF_IRQMASK)) rdata_d[2:0] = irqmask_q;
	end

	// Answer in the setup cycle so the access phase completes at once
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PRDATA  <= '0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= 1'b0;
			if (PSEL & ~PENABLE & ~PWRITE) PRDATA <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// Buffer: a write fills it, the shifter empties it
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			txbuf_q  <= BYTE_ZERO;
			txfull_q <= 1'b0;
		end else if (wr && hit(PADDR, OFF_TXDATA)) begin
			txbuf_q  <= PWDATA[7:0]; // Overwrite while full is not guarded
			txfull_q <= 1'b1;
		end else if (tx_load) begin
			txfull_q <= 1'b0;
		end
	end

	// Shifter: start, eight data bits LSB first, one or two stop bits
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			txst_q    <= TX_IDLE;
			txsh_q    <= BYTE_ZERO;
			txcnt_q   <= '0;
			txbit_q   <= '0;
			txstop2_q <= 1'b0;
			TXD       <= LINE_IDLE;
		end else begin
			txcnt_q <= tx_tick ? baud_q : txcnt_q - 1'b1;
			case (txst_q)
				TX_IDLE: begin
					TXD <= LINE_IDLE;
					if (tx_load) begin
						txsh_q    <= txbuf_q;
						txstop2_q <= ctrl_q[CTL_STOP2_BIT];
						txcnt_q   <= baud_q;
						TXD       <= 1'b0;
						txst_q    <= TX_START;
					end
				end
				TX_START: if (tx_tick) begin
					TXD     <= txsh_q[0];
					txbit_q <= '0;
					txst_q  <= TX_DATA;
				end
				TX_DATA: if (tx_tick) begin
					if (txbit_q == 3'(DATA_BITS - 1)) begin
						TXD    <= LINE_IDLE;
						txst_q <= TX_STOP;
					end else begin
						TXD     <= txsh_q[txbit_q + 3'd1];
						txbit_q <= txbit_q + 3'd1;
					end
				end
				TX_STOP: if (tx_tick) begin
					if (txstop2_q) txstop2_q <= 1'b0;
					else           txst_q    <= TX_IDLE;
				end
				default: txst_q <= TX_IDLE;
			endcase
		end
	end

	assign tx_done = (txst_q == TX_STOP) & tx_tick & ~txstop2_q;

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	// Samples mid-bit; checks only the first stop bit
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rxst_q  <= RX_IDLE;
			rxsh_q  <= BYTE_ZERO;
			rxcnt_q <= '0;
			rxbit_q <= '0;
		end else begin
			rxcnt_q <= rx_tick ? baud_q : rxcnt_q - 1'b1;
			case (rxst_q)
				RX_IDLE: if (ctrl_q[CTL_RXEN_BIT] && !RXD) begin
					rxcnt_q <= baud_q >> 1; // Half period to mid start bit
					rxst_q  <= RX_START;
				end
				RX_START: if (rx_tick) begin
					rxbit_q <= '0;
					rxst_q  <= RXD ? RX_IDLE : RX_DATA; // Glitch rejected
				end
				RX_DATA: if (rx_tick) begin
					rxsh_q <= {RXD, rxsh_q[7:1]};
					if (rxbit_q == 3'(DATA_BITS - 1)) rxst_q <= RX_STOP;
					rxbit_q <= rxbit_q + 3'd1;
				end
				RX_STOP: if (rx_tick) rxst_q <= RX_IDLE;
				default: rxst_q <= RX_IDLE;
			endcase
		end
	end

	assign rx_done = (rxst_q == RX_STOP) & rx_tick;
	assign rx_err  = rx_done & (~RXD | rxfull_q);

	// Receive buffer and error status; errors stick until status read
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rxbuf_q  <= BYTE_ZERO;
			rxfull_q <= 1'b0;
			err_q    <= '0;
		end else begin
			if (rx_done) begin
				rxbuf_q  <= rxsh_q;
				rxfull_q <= 1'b1;
			end else if (rd && hit(PADDR, OFF_RXDATA)) begin
				rxfull_q <= 1'b0;
			end
			if (rx_done) begin
				err_q.frame_err <= err_q.frame_err | ~RXD;
				err_q.overrun   <= err_q.overrun | rxfull_q;
			end else if (rd && hit(PADDR, OFF_ERRSTAT)) begin
				err_q <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Sticky status; set beats read clear
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irqst_q <= '0;
			IRQ     <= 1'b0;
		end else begin
			if (rd && hit(PADDR, OFF_IRQSTAT)) irqst_q <= {rx_err, rx_done, tx_done};
			else irqst_q <= irqst_q | {rx_err, rx_done, tx_done};
			IRQ <= |(irqst_q & irqmask_q);
		end
	end

endmodule

// [design/uatx_pkg.sv]
// Package for the serial transmitter/receiver with buffered transmit path.
// Assumes one peripheral clock and an APB master at the register port.
package uatx_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL    = 8'h00; // Control: enables, stop bits
	localparam logic [7:0] OFF_BAUD    = 8'h04; // Baud divider
	localparam logic [7:0] OFF_TXDATA  = 8'h08; // Transmit buffer
	localparam logic [7:0] OFF_RXDATA  = 8'h0C; // Receive buffer
	localparam logic [7:0] OFF_TXSTAT  = 8'h10; // Transmit status
	localparam logic [7:0] OFF_ERRSTAT = 8'h14; // Reception error status
	localparam logic [7:0] OFF_IRQSTAT = 8'h18; // Interrupt status, read clears
	localparam logic [7:0] OFF_IRQMASK = 8'h1C; // Interrupt mask

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TXS_SHIFT_BIT = 0; // Shift busy in transmit status
	localparam int TXS_FULL_BIT  = 1; // Buffer full in transmit status
	localparam int CTL_TXEN_BIT  = 0; // Transmitter enable
	localparam int CTL_RXEN_BIT  = 1; // Receiver enable
	localparam int CTL_STOP2_BIT = 2; // Two stop bits on transmit
	localparam int ERR_FRAME_BIT = 0; // Stop bit low
	localparam int ERR_OVR_BIT   = 1; // Overrun
	localparam int IRQ_TXDONE    = 0; // Transmission complete
	localparam int IRQ_RXDONE    = 1; // Reception complete
	localparam int IRQ_RXERR     = 2; // Reception error

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [15:0] BAUD_RST  = 16'h00D9; // Near 115200 at 25 MHz
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic        LINE_IDLE = 1'b1;
	localparam int          DATA_BITS = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uatx_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uatx_rx_e;

	typedef struct packed {
		logic frame_err; // Stop bit sampled low
		logic overrun;   // Unread byte overwritten
	} uatx_err_s;

endpackage

// [dv/uatx_monitor.sv]
// Port checker for the serial block.
// Assumes it is bound to uatx_top and sees only its ports.
`timescale 1ns/1ns
module uatx_monitor
	import uatx_pkg::*;
(
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        TXD,
	input wire logic        IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire rd_txs = PREADY & ~PWRITE & (PADDR == OFF_TXSTAT); // Status read
	wire rd_irq = PREADY & ~PWRITE & (PADDR == OFF_IRQSTAT); // Event read
	// --------------------------------------------------------
	// Assertions
	// --------------------------------------------------------
	ready_in_access_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("ready missing in access phase");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	no_slverr_a: assert property (PREADY |-> !PSLVERR)
		else $error("error response");
	unmapped_zero_a: assert property (PREADY && !PWRITE && PADDR >= 8'h20 |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	full_needs_busy_a: assert property (rd_txs && PRDATA[1] |-> PRDATA[0])
		else $error("buffer full with idle shifter");
	idle_line_a: assert property (rd_txs && !PRDATA[0] |-> TXD)
		else $error("line active while shifter idle");
	reset_idle_a: assert property ($fell(SYS_RST) |-> TXD && !IRQ)
		else $error("outputs not idle after reset");
	irq_clear_a: assert property (rd_irq && PRDATA != 32'h0 |-> ##[1:2] !IRQ)
		else $error("interrupt stays after clear");
	cover property (rd_txs && PRDATA[1]);
	cover property (PREADY && !PWRITE && PADDR == OFF_ERRSTAT && PRDATA[1]);
	cover property ($rose(IRQ));
endmodule
bind uatx_top uatx_monitor MON (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PRDATA, .PREADY, .PSLVERR, .TXD, .IRQ);

// [dv/uatx_partner.sv]
// Remote serial device model: sends frames on RXD, collects TXD bytes.
// Assumes the block's bit time equals BIT_CLKS clocks.
`timescale 1ns/1ns
module uatx_partner #(
	parameter int BIT_CLKS = 4 // Same bit time as the block
) (
	input wire logic CLK,
	input wire logic TXD,
	output logic     RXD
);
	logic [7:0] got_q[$]; // Bytes seen on the block's line
	logic [7:0] sh;       // Receive shifter
	initial RXD = 1'b1;
	// Sends start, eight data bits LSB first, then nstop stop bits
	task automatic send(input logic [7:0] b, input logic stop, input int nstop);
		logic [8:0] f;
		f = {b, 1'b0};
		for (int i = 0; i < 9 + nstop; i++) begin
			RXD <= (i < 9) ? f[i] : stop;
			repeat (BIT_CLKS) @(posedge CLK);
		end
		RXD <= 1'b1;
		repeat (BIT_CLKS) @(posedge CLK); // Idle bit: next start is a clean edge
	endtask
	// Samples each frame in mid-bit
	always begin
		@(negedge TXD);
		repeat (BIT_CLKS * 3 / 2) @(posedge CLK);
		for (int i = 0; i < 8; i++) begin
			sh[i] = TXD;
			repeat (BIT_CLKS) @(posedge CLK);
		end
		got_q.push_back(sh);
	end
endmodule

// [dv/uatx_top_tb.sv]
// Testbench for the serial block: APB tasks and a remote partner.
// Assumes a 25 MHz clock and a bit time of four clocks.
`timescale 1ns/1ns
module uatx_top_tb
	import uatx_pkg::*;
;
	logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 8'h00; // Bus address
	logic [31:0] PWDATA = 32'h0, PRDATA; // Bus data
	logic PREADY, PSLVERR, RXD, TXD, IRQ; // Block outputs and line
	int err_total = 0, comparisons = 0;
	logic [7:0] sent[3] = '{8'h81, 8'hA5, 8'h3C}; // Expected line bytes
	uatx_top DUT (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .RXD, .TXD, .IRQ);
	uatx_partner #(.BIT_CLKS(4)) PEER (.CLK, .TXD, .RXD);
	initial forever #20 CLK = ~CLK;
	// --------------------------------------------------------
	// Tasks
	// --------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer, waits for ready, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1)
			@(posedge CLK);
		q = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask
	// Polls transmit status until the given bits read zero
	task automatic wait_tx(input logic [31:0] m);
		logic [31:0] q;
		q = m;
		for (int n = 0; n < 200 && (q & m) != 0; n++)
			apb(1'b0, OFF_TXSTAT, 32'h0, q);
		cmp(q & m, 32'h0);
	endtask
	initial begin
		#(40 * 20000);
		err_total++;
		print_verdict();
	end
	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		chk(OFF_CTRL, 32'h0);
		chk(OFF_BAUD, 32'hD9);
		chk(OFF_TXSTAT, 32'h0);
		wr(8'h20, 32'hFF);
		chk(8'h20, 32'h0);
		cmp(IRQ, 1'b0);
		$display("test reset done");
		wr(OFF_BAUD, 32'h3);
		wr(OFF_CTRL, 32'h3);
		wr(OFF_IRQMASK, 32'h0);
		wr(OFF_TXDATA, sent[0]);
		wait_tx(32'h3);
		cmp(IRQ, 1'b0);
		chk(OFF_IRQSTAT, 32'h1);
		wr(OFF_IRQMASK, 32'h1);
		wr(OFF_TXDATA, sent[1]);
		wait_tx(32'h2);
		wr(OFF_TXDATA, sent[2]);
		chk(OFF_TXSTAT, 32'h3);
		wait_tx(32'h3);
		cmp(IRQ, 1'b1);
		chk(OFF_IRQSTAT, 32'h1);
		chk(OFF_IRQSTAT, 32'h0);
		cmp(IRQ, 1'b0);
		for (int i = 0; i < 3; i++)
			cmp(PEER.got_q[i], sent[i]);
		$display("test transmit done");
		PEER.send(8'h5A, 1'b1, 2);
		repeat (4) @(posedge CLK);
		chk(OFF_ERRSTAT, 32'h0);
		chk(OFF_RXDATA, 32'h5A);
		PEER.send(8'h11, 1'b0, 1);
		PEER.send(8'h22, 1'b1, 1);
		repeat (4) @(posedge CLK);
		chk(OFF_ERRSTAT, 32'h3);
		chk(OFF_RXDATA, 32'h22);
		chk(OFF_IRQSTAT, 32'h6);
		$display("test receive done");
		// Two stop bits: shifter still busy after one stop bit time
		wr(OFF_CTRL, 32'h7);
		wr(OFF_TXDATA, 32'hC3);
		repeat (41) @(posedge CLK);
		chk(OFF_TXSTAT, 32'h1);
		wait_tx(32'h3);
		cmp(PEER.got_q[3], 8'hC3);
		$display("test two stop bits done");
		print_verdict();
	end
endmodule
